/* File: common/serial_periph_pkg.sv */
// constants and types shared by the serial peripheral interface files
package serial_periph_pkg;
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_RX = 8'h08;
   localparam logic [7:0] ADDR_TX = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_SET = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
   localparam logic [7:0] ADDR_IRQ_VIEW = 8'h1c;
   localparam logic [7:0] ADDR_SEL0 = 8'h30;
   localparam logic [7:0] ADDR_SEL1 = 8'h34;
   localparam logic [7:0] ADDR_SEL2 = 8'h38;
   localparam logic [7:0] ADDR_SEL3 = 8'h3c;
   localparam int CR_ENABLE = 0;
   localparam int CR_DISABLE = 1;
   localparam int CR_SOFT_RESET = 7;
   localparam int CR_LAST = 24;
   localparam int MR_MASTER = 0;
   localparam int MR_SELECT_MODE = 1;
   localparam int MR_DECODE = 2;
   localparam int MR_FAULT_DIS = 4;
   localparam int MR_LOOPBACK = 7;
   localparam int MR_PCS_LSB = 16;
   localparam int MR_DELAY_LSB = 24;
   localparam int TX_PCS_LSB = 16;
   localparam int TX_LAST = 24;
   localparam int SEL_HOLD = 3;
   localparam logic [31:0] MODE_MASK = 32'hff0f_0097;
   localparam logic [31:0] SEL_MASK = 32'hffff_fffb;
   localparam logic [31:0] IRQ_MASK = 32'h0000_03ff;
   localparam logic [31:0] MODE_RESET = 32'h0000_0000;
   localparam logic [31:0] SEL_RESET = 32'h0000_0000;
   localparam logic [31:0] STATUS_DMA_IDLE = 32'h0000_00f0;
   localparam logic [3:0] CS_NONE = 4'hf;
   localparam logic [7:0] MIN_SELECT_GAP = 8'h06;
   localparam logic [2:0] SCLK_HALF = 3'h4;
   localparam logic [3:0] CHAR_BITS = 4'h8;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_GAP = 2'b01,
      ST_SHIFT = 2'b11
   } xfer_state_e;
endpackage

/* File: common/shift_if.sv */
// link between the register block and the serializer
`timescale 1ns/1ps
`default_nettype none
interface shift_if;
   logic start, master, loop, busy, done, sck_in, sdi_m, sdi_s, ss_n, sck_out, sdo;
   logic [7:0] tx_byte;
   logic [7:0] rx_byte;
   modport ctrl(output start, master, loop, tx_byte, sck_in, sdi_m, sdi_s, ss_n,
      input busy, done, rx_byte, sck_out, sdo);
   modport eng(input start, master, loop, tx_byte, sck_in, sdi_m, sdi_s, ss_n,
      output busy, done, rx_byte, sck_out, sdo);
endinterface
`default_nettype wire

/* File: dv/spi_slave_model.sv */
// behavioural serial slave on select 0, mode 0, msb first
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic [7:0] reply,
   output logic miso,
   output logic [7:0] got
);
   logic [7:0] sh = 8'h00;
   initial got = 8'h00;
   always @(negedge cs_n) sh = reply;
   always @(posedge sclk) if (!cs_n) got = {got[6:0], mosi};
   always @(negedge sclk) if (!cs_n) sh = {sh[6:0], 1'b0};
   // released line floats to the pull-up level
   assign miso = cs_n ? 1'b1 : sh[7];
endmodule
`default_nettype wire

/* File: dv/test_serial_periph_iface_regs.sv */
// self-checking bench for the serial peripheral interface register block
`timescale 1ns/1ps
`default_nettype none
module test_serial_periph_iface_regs;
   import serial_periph_pkg::*;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
   logic [3:0] chip_select_out_n;
   logic [3:0] chip_select_oe_n;
   logic lk = 1'b0;
   logic ss_n = 1'b1;
   logic mo = 1'b1;
   logic [7:0] reply = 8'h3c;
   logic [7:0] got, sb;
   logic model_miso;
   int miscompares = 0;
   int comparisons = 0;
   int g1, g2, g3, n;
   logic [3:0] cs;
   wire logic sclk_line = sclk_oe_n ? lk : sclk_out;
   wire logic mosi_line = mosi_oe_n ? mo : mosi_out;
   wire logic miso_line = miso_oe_n ? model_miso : miso_out;
   wire logic cs0_line = (chip_select_oe_n[0] | chip_select_out_n[0]) & ss_n;

   serial_periph_iface_regs u_dut (.clk_sys(clk_sys), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sclk_in(sclk_line), .sclk_out(sclk_out),
      .sclk_oe_n(sclk_oe_n), .mosi_in(mosi_line), .mosi_out(mosi_out),
      .mosi_oe_n(mosi_oe_n), .miso_in(miso_line), .miso_out(miso_out),
      .miso_oe_n(miso_oe_n), .chip_select0_in_n(cs0_line),
      .chip_select_out_n(chip_select_out_n), .chip_select_oe_n(chip_select_oe_n));
   spi_slave_model u_slave (.sclk(sclk_line), .cs_n(cs0_line), .mosi(mosi_line),
      .reply(reply), .miso(model_miso), .got(got));

   always #5 clk_sys = ~clk_sys;

   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      comparisons++;
      if (got_v !== exp_v) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got_v, exp_v);
      end
   endtask

   task end_sim;
      if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   function automatic logic [31:0] oe();
      return {25'h0, sclk_oe_n, mosi_oe_n, miso_oe_n, chip_select_oe_n};
   endfunction

   // one bus cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int k;
      k = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) chk(32'h0000_0001, 32'h0000_0000);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(q & m, e);
   endtask

   task automatic wait_cs(input logic lo, output int k);
      k = 0;
      while (((chip_select_out_n !== 4'hf) != lo) && k < 3000) begin
         @(posedge clk_sys);
         k++;
      end
      if (k >= 3000) chk(32'h0000_0001, 32'h0000_0000);
   endtask

   task automatic xfer(input logic [31:0] d, output int gap, output logic [3:0] sel);
      int k;
      wr(ADDR_TX, d);
      wait_cs(1'b1, gap);
      sel = chip_select_out_n;
      wait_cs(1'b0, k);
      repeat (4) @(posedge clk_sys);
   endtask

   // external master frame on the link clock, 125 ns period
   task automatic frame(input logic [7:0] b);
      ss_n <= 1'b0;
      mo <= b[7];
      #40;
      for (int i = 6; i >= -1; i--) begin
         #62.5 sb = {sb[6:0], miso_line};
         lk = 1'b1;
         #62.5 lk = 1'b0;
         if (i >= 0) mo = b[i];
      end
      #42 ss_n = 1'b1;
      mo = 1'b1;
      @(posedge clk_sys);
   endtask

   task t_reset;
      rd_chk(ADDR_STATUS, ALL, STATUS_DMA_IDLE);
      rd_chk(ADDR_MODE, ALL, MODE_RESET);
      rd_chk(ADDR_RX, ALL, 32'h0000_0000);
      rd_chk(8'h20, ALL, 32'h0000_0000);
      wr(ADDR_SEL0, ALL);
      rd_chk(ADDR_SEL0, ALL, SEL_MASK);
      wr(ADDR_SEL0, SEL_RESET);
      wr(ADDR_IRQ_SET, ALL);
      rd_chk(ADDR_IRQ_VIEW, ALL, IRQ_MASK);
      wr(ADDR_MODE, ALL);
      rd_chk(ADDR_MODE, ALL, MODE_MASK);
      wr(ADDR_MODE, MODE_RESET);
      wr(ADDR_CONTROL, 32'h0000_0000);
      rd_chk(ADDR_STATUS, ALL, STATUS_DMA_IDLE);
      wr(ADDR_CONTROL, 32'h0000_0001);
      rd_chk(ADDR_STATUS, ALL, 32'h0001_02f2);
      chk(oe(), 32'h0000_007f);
   endtask

   task t_master;
      wr(ADDR_MODE, 32'h000e_0001);
      chk(oe(), 32'h0000_0010);
      xfer(32'h0007_00a5, g1, cs);
      chk({28'h0, cs}, 32'h0000_000e);
      chk({24'h0, got}, 32'h0000_00a5);
      rd_chk(ADDR_STATUS, ALL, 32'h0001_02f3);
      rd_chk(ADDR_RX, ALL, 32'h000e_003c);
      rd_chk(ADDR_STATUS, ALL, 32'h0001_02f2);
      wr(ADDR_MODE, 32'h000e_0081);
      xfer(32'h0000_005a, g1, cs);
      xfer(32'h0000_00c3, g1, cs);
      rd_chk(ADDR_STATUS, 32'h0000_0009, 32'h0000_0009);
      rd_chk(ADDR_RX, 32'h0000_ffff, 32'h0000_00c3);
      rd_chk(ADDR_STATUS, 32'h0000_0009, 32'h0000_0000);
   endtask

   task t_gap;
      wr(ADDR_MODE, 32'h0a0e_0001);
      xfer(32'h0000_0011, g1, cs);
      wr(ADDR_MODE, 32'h140e_0001);
      xfer(32'h0000_0022, g2, cs);
      wr(ADDR_MODE, 32'h030e_0001);
      xfer(32'h0000_0033, g3, cs);
      chk(g2 - g1, 32'h0000_000a);
      chk(g1 - g3, 32'h0000_0004);
   endtask

   task t_select;
      logic [3:0] pv [4] = '{4'h6, 4'h9, 4'h3, 4'h7};
      logic [3:0] ev [4] = '{4'he, 4'hd, 4'hb, 4'h7};
      wr(ADDR_MODE, 32'h0000_0003);
      foreach (pv[i]) begin
         xfer({12'h0, pv[i], 16'h0044}, g1, cs);
         chk({28'h0, cs}, {28'h0, ev[i]});
      end
      wr(ADDR_MODE, 32'h000c_0005);
      xfer(32'h0003_0044, g1, cs);
      chk({28'h0, cs}, 32'h0000_000c);
      wr(ADDR_SEL1, 32'h0000_0008);
      wr(ADDR_MODE, 32'h0000_0007);
      wr(ADDR_TX, 32'h0005_0055);
      wait_cs(1'b1, n);
      repeat (200) @(posedge clk_sys);
      chk({28'h0, chip_select_out_n}, 32'h0000_0005);
      wr(ADDR_CONTROL, 32'h0100_0000);
      wait_cs(1'b0, n);
      xfer(32'h0002_0066, g1, cs);
      chk({28'h0, cs}, 32'h0000_0002);
      xfer(32'h0105_0077, g1, cs);
      wr(ADDR_SEL1, SEL_RESET);
   endtask

   task t_fault;
      wr(ADDR_MODE, 32'h000e_0011);
      ss_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rd_chk(ADDR_STATUS, 32'h0001_0004, 32'h0001_0000);
      wr(ADDR_MODE, 32'h000e_0001);
      repeat (10) @(posedge clk_sys);
      rd_chk(ADDR_STATUS, 32'h0001_0004, 32'h0000_0004);
      ss_n <= 1'b1;
      wr(ADDR_CONTROL, 32'h0000_0001);
   endtask

   task t_disable;
      wr(ADDR_TX, 32'h0000_0069);
      wr(ADDR_CONTROL, 32'h0000_0002);
      wait_cs(1'b1, n);
      wait_cs(1'b0, n);
      repeat (4) @(posedge clk_sys);
      chk({24'h0, got}, 32'h0000_0069);
      rd_chk(ADDR_STATUS, 32'h0001_0000, 32'h0000_0000);
      chk(oe(), 32'h0000_007f);
      wr(ADDR_TX, 32'h0000_0012);
      repeat (100) @(posedge clk_sys);
      chk({28'h0, chip_select_out_n}, 32'h0000_000f);
      wr(ADDR_CONTROL, 32'h0000_0003);
      rd_chk(ADDR_STATUS, 32'h0001_0000, 32'h0000_0000);
   endtask

   task t_slave;
      wr(ADDR_CONTROL, 32'h0000_0080);
      rd_chk(ADDR_MODE, ALL, MODE_RESET);
      rd_chk(ADDR_STATUS, ALL, STATUS_DMA_IDLE);
      wr(ADDR_CONTROL, 32'h0000_0001);
      wr(ADDR_TX, 32'h0000_00a9);
      frame(8'h96);
      repeat (20) @(posedge clk_sys);
      rd_chk(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
      rd_chk(ADDR_RX, ALL, 32'h0000_0096);
      chk({24'h0, sb}, 32'h0000_00a9);
   endtask

   initial begin
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_master();
      t_gap();
      t_select();
      t_fault();
      t_disable();
      t_slave();
      end_sim();
   end

   initial begin
      #500000;
      miscompares++;
      end_sim();
   end
endmodule
`default_nettype wire

/* File: logic/serial_periph_iface_regs.sv */
// register block and transfer control of the serial peripheral interface
// Behaviour
// R1 - writing one to enable bit turns the interface on; zero does nothing
// R2 - disable bit stops the interface after any running transfer ends
// R3 - while disabled every pin is input and nothing moves
// R4 - enable and disable in one write leaves the interface disabled
// R5 - soft reset bit resets everything to slave mode, DMA untouched; here the serializer u_shifter resets on srst only
// R6 - last-transfer bit releases the select after the current character
// R7 - master-select bit: zero slave, one master
// R8 - fixed selection uses the mode select field, variable ignores it
// R9 - decode mode drives the select field straight onto the four outputs
// R10 - in decode mode select registers each cover four decoded selects
// R11 - fault-detect-disable zero enables mode fault detection, one disables
// R12 - loopback routes serializer output to input, master mode only
// R13 - gap before asserting a select: delay field cycles, at least six
// R14 - received characters sit right-justified, unused upper bits zero
// R15 - receive select field shows select pins in master, zero in slave
// R16 - writers place transmit characters right-justified
// R17 - non-decoded variable select maps lowest zero bit, all ones selects none
// R18 - receive-full sets on a new character and clears on its read
// R19 - transmit-empty is zero while disabled, enable sets it
// R20 - overrun sets on a second unread load, clears on status read
// R21 - enabled-status reads one while enabled, zero while disabled
// R22 - reserved bits read zero and ignore writes
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module serial_periph_iface_regs
   import serial_periph_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe_n,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe_n,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe_n,
   input wire logic chip_select0_in_n,
   output logic [3:0] chip_select_out_n,
   output logic [3:0] chip_select_oe_n
);
   shift_if sh();
   serial_shifter u_shifter (
      .clk_sys(clk_sys),
      .srst(srst),
      .sh(sh)
   );

   // two-stage synchronisers for pin inputs
   logic [3:0] pin_raw, pin_meta, pin_sync;
   assign pin_raw = {chip_select0_in_n, miso_in, mosi_in, sclk_in};
   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            pin_meta[i] <= 1'b1;
            pin_sync[i] <= 1'b1;
         end else begin
            pin_meta[i] <= pin_raw[i];
            pin_sync[i] <= pin_meta[i];
         end
      end
   end

   // bus slave: one wait cycle, answer at the second edge
   logic ack, wr_acc, rd_acc, sw_rst;
   logic [31:0] wd, rd_mux;
   assign wd = avs_writedata;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_acc = avs_write & ack;
   assign rd_acc = avs_read & ack;
   assign sw_rst = wr_acc && avs_address == ADDR_CONTROL && wd[CR_SOFT_RESET]; // R5
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read | avs_write) & ~ack;
      end
   end

   logic [31:0] mode_config, irq_mask;
   logic [31:0] sel_cfg [4];
   logic [15:0] tx_data, rx_data;
   logic [3:0] tx_pcs, rx_pcs, cs_q, tgt_cs, sel_pcs;
   logic [1:0] cs_idx, cur_idx, cs0_hist;
   logic [7:0] gap_cnt, gap_len;
   logic tx_last, tx_pend, cur_last, last_req, enabled, dis_pend;
   logic receive_full, overrun_flag, mode_fault_flag, transmit_empty, rx_load, start_m, start_s, hold, fault_hit;
   xfer_state_e state;

   logic master, decode;
   assign master = mode_config[MR_MASTER]; // R7
   assign decode = mode_config[MR_DECODE];

   // select mapping, lowest zero wins when not decoding
   function automatic logic [3:0] cs_map(input logic [3:0] chip_select_field, input logic dec);
      logic [3:0] r;
      r = CS_NONE;
      if (dec) begin
         r = chip_select_field; // R9
      end else if (!chip_select_field[0]) begin
         r = 4'he; // R17
      end else if (!chip_select_field[1]) begin
         r = 4'hd;
      end else if (!chip_select_field[2]) begin
         r = 4'hb;
      end else if (!chip_select_field[3]) begin
         r = 4'h7;
      end
      return r;
   endfunction

   always_comb begin
      // R8
      sel_pcs = mode_config[MR_SELECT_MODE] ? tx_pcs : mode_config[MR_PCS_LSB +: 4];
      tgt_cs = cs_map(sel_pcs, decode);
      if (decode) begin
         cs_idx = sel_pcs[3:2]; // R10
      end else if (!sel_pcs[0]) begin
         cs_idx = 2'h0;
      end else if (!sel_pcs[1]) begin
         cs_idx = 2'h1;
      end else if (!sel_pcs[2]) begin
         cs_idx = 2'h2;
      end else begin
         cs_idx = 2'h3;
      end
      gap_len = (mode_config[MR_DELAY_LSB +: 8] <= MIN_SELECT_GAP) ?
         MIN_SELECT_GAP : mode_config[MR_DELAY_LSB +: 8]; // R13
      start_m = enabled && master && ((state == ST_GAP && gap_cnt == 8'h01) ||
         (state == ST_IDLE && tx_pend && !dis_pend && cs_q == tgt_cs && cs_q != CS_NONE));
      start_s = enabled && !master && tx_pend && !sh.busy;
      hold = sel_cfg[cur_idx][SEL_HOLD] && !cur_last && !last_req; // R6
      // own select 0 must have been high long enough for its pin to follow
      fault_hit = enabled && master && !mode_config[MR_FAULT_DIS] && cs_q[0] &&
         (&cs0_hist) && !pin_sync[3]; // R11
   end

   assign sh.start = start_m | start_s;
   assign sh.master = master;
   assign sh.loop = master & mode_config[MR_LOOPBACK]; // R12
   assign sh.tx_byte = tx_data[7:0];
   assign sh.sck_in = pin_sync[0];
   assign sh.sdi_s = pin_sync[1];
   assign sh.sdi_m = pin_sync[2];
   assign sh.ss_n = (enabled && !master) ? pin_sync[3] : 1'b1; // R3
   assign rx_load = sh.done & enabled;

   // configuration registers
   always_ff @(posedge clk_sys) begin
      if (srst || sw_rst) begin
         mode_config <= MODE_RESET; // R5
         irq_mask <= 32'h0000_0000;
         for (int k = 0; k < 4; k++) begin
            sel_cfg[k] <= SEL_RESET;
         end
      end else if (wr_acc) begin
         if (avs_address == ADDR_MODE) begin
            mode_config <= wd & MODE_MASK; // R22
         end else if (avs_address == ADDR_IRQ_SET) begin
            irq_mask <= irq_mask | (wd & IRQ_MASK);
         end else if (avs_address == ADDR_IRQ_CLR) begin
            irq_mask <= irq_mask & ~wd;
         end else if (avs_address >= ADDR_SEL0 && avs_address <= ADDR_SEL3) begin
            sel_cfg[avs_address[3:2]] <= wd & SEL_MASK;
         end
      end
   end

   // transmit holding register
   always_ff @(posedge clk_sys) begin
      if (srst || sw_rst) begin
         tx_data <= 16'h0000;
         tx_pcs <= CS_NONE;
         tx_last <= 1'b0;
         tx_pend <= 1'b0;
      end else if (wr_acc && avs_address == ADDR_TX) begin
         tx_data <= wd[15:0]; // R16
         tx_pcs <= wd[TX_PCS_LSB +: 4];
         tx_last <= wd[TX_LAST] & mode_config[MR_SELECT_MODE];
         tx_pend <= 1'b1;
      end else if (sh.start) begin
         tx_pend <= 1'b0;
      end
   end

   // enable, disable and mode fault
   always_ff @(posedge clk_sys) begin
      if (srst || sw_rst) begin
         enabled <= 1'b0;
         dis_pend <= 1'b0;
         mode_fault_flag <= 1'b0;
      end else begin
         if (wr_acc && avs_address == ADDR_CONTROL && wd[CR_DISABLE]) begin
            dis_pend <= 1'b1; // R4
         end else if (wr_acc && avs_address == ADDR_CONTROL && wd[CR_ENABLE]) begin
            enabled <= 1'b1; // R1
            dis_pend <= 1'b0;
         end else if (dis_pend && state == ST_IDLE && !sh.busy) begin
            enabled <= 1'b0; // R2
            dis_pend <= 1'b0;
         end
         if (fault_hit) begin
            mode_fault_flag <= 1'b1; // R11
            enabled <= 1'b0;
         end else if (rd_acc && avs_address == ADDR_STATUS) begin
            mode_fault_flag <= 1'b0;
         end
      end
   end

   // master transfer sequencing and chip selects
   always_ff @(posedge clk_sys) begin
      if (srst || sw_rst) begin
         state <= ST_IDLE;
         cs_q <= CS_NONE;
         gap_cnt <= 8'h00;
         cur_idx <= 2'h0;
         cur_last <= 1'b0;
         last_req <= 1'b0;
         cs0_hist <= 2'b00;
      end else begin
         cs0_hist <= {cs0_hist[0], cs_q[0]};
         if (wr_acc && avs_address == ADDR_CONTROL && wd[CR_LAST]) begin
            last_req <= 1'b1;
         end
         if (!enabled || !master) begin
            state <= ST_IDLE;
            cs_q <= CS_NONE;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (start_m) begin
                     state <= ST_SHIFT;
                     cur_idx <= cs_idx;
                     cur_last <= tx_last;
                  end else if (tx_pend && !dis_pend) begin
                     cs_q <= CS_NONE;
                     gap_cnt <= gap_len; // R13
                     state <= ST_GAP;
                  end else if (last_req && cs_q != CS_NONE) begin
                     cs_q <= CS_NONE; // R6
                     last_req <= 1'b0;
                  end
               end
               ST_GAP: begin
                  gap_cnt <= gap_cnt - 8'h01;
                  if (gap_cnt == 8'h01) begin
                     cs_q <= tgt_cs;
                     cur_idx <= cs_idx;
                     cur_last <= tx_last;
                     state <= ST_SHIFT;
                  end
               end
               ST_SHIFT: begin
                  if (sh.done) begin
                     state <= ST_IDLE;
                     if (!hold) begin
                        cs_q <= CS_NONE; // R6
                        last_req <= 1'b0;
                     end
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // receive holding and receive flags
   always_ff @(posedge clk_sys) begin
      if (srst || sw_rst) begin
         rx_data <= 16'h0000;
         rx_pcs <= 4'h0;
         receive_full <= 1'b0;
         overrun_flag <= 1'b0;
      end else begin
         if (rx_load) begin
            rx_data <= {8'h00, sh.rx_byte}; // R14
            rx_pcs <= master ? cs_q : 4'h0; // R15
            receive_full <= 1'b1; // R18
         end else if (rd_acc && avs_address == ADDR_RX) begin
            receive_full <= 1'b0;
         end
         if (rx_load && receive_full) begin
            overrun_flag <= 1'b1; // R20
         end else if (rd_acc && avs_address == ADDR_STATUS) begin
            overrun_flag <= 1'b0;
         end
      end
   end

   // transmit-empty
   always_ff @(posedge clk_sys) begin
      if (srst || sw_rst) begin
         transmit_empty <= 1'b0;
      end else if (!enabled || dis_pend || fault_hit) begin
         transmit_empty <= wr_acc && avs_address == ADDR_CONTROL && wd[CR_ENABLE] &&
            !wd[CR_DISABLE]; // R19
      end else if (sh.start) begin
         transmit_empty <= 1'b1;
      end else if (wr_acc && avs_address == ADDR_TX) begin
         transmit_empty <= 1'b0;
      end
   end

   // read mux and registered read data
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (avs_address == ADDR_MODE) begin
         rd_mux = mode_config;
      end else if (avs_address == ADDR_RX) begin
         rd_mux = {12'h000, rx_pcs, rx_data}; // R14
      end else if (avs_address == ADDR_STATUS) begin
         rd_mux = STATUS_DMA_IDLE | {15'h0000, enabled, 6'h00, // R21
            transmit_empty & ~sh.busy & ~tx_pend, 5'h00, overrun_flag, mode_fault_flag, transmit_empty, receive_full};
      end else if (avs_address == ADDR_IRQ_VIEW) begin
         rd_mux = irq_mask;
      end else if (avs_address >= ADDR_SEL0 && avs_address <= ADDR_SEL3) begin
         rd_mux = sel_cfg[avs_address[3:2]];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack) begin
         avs_readdata <= rd_mux;
      end
   end

   // pins: inputs only while disabled
   assign sclk_out = sh.sck_out;
   assign mosi_out = sh.sdo;
   assign miso_out = sh.sdo;
   assign chip_select_out_n = cs_q;
   assign sclk_oe_n = ~(enabled & master); // R3
   assign mosi_oe_n = ~(enabled & master);
   assign chip_select_oe_n = {4{~(enabled & master)}};
   assign miso_oe_n = ~(enabled & ~master & ~pin_sync[3]);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   property p_enable;
      wr_acc && avs_address == ADDR_CONTROL && wd[CR_ENABLE] && !wd[CR_DISABLE] &&
         !wd[CR_SOFT_RESET] |=> enabled ##0 transmit_empty;
   endproperty
   a_enable: assert property (p_enable) else $error("enable ignored"); // R1
   property p_both;
      wr_acc && avs_address == ADDR_CONTROL && wd[CR_ENABLE] && wd[CR_DISABLE] && !enabled
         |=> !enabled;
   endproperty
   a_both: assert property (p_both) else $error("enable won over disable"); // R4
   property p_pins_idle;
      !enabled |-> sclk_oe_n && mosi_oe_n && miso_oe_n && (&chip_select_oe_n);
   endproperty
   a_pins_idle: assert property (p_pins_idle) else $error("pin driven while off"); // R3
   property p_soft;
      sw_rst |=> !master && !enabled && !receive_full;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset incomplete"); // R5
   property p_gap;
      @(posedge clk_sys) disable iff (srst || sw_rst || !enabled)
         $rose(state == ST_GAP) |-> (state == ST_GAP && cs_q == CS_NONE)[*6];
   endproperty
   a_gap: assert property (p_gap) else $error("select gap too short"); // R13
   property p_full;
      rx_load |=> receive_full && rx_data[15:8] == 8'h00 && rx_data[7:0] == $past(sh.rx_byte);
   endproperty
   a_full: assert property (p_full) else $error("receive not captured"); // R18
   property p_overrun;
      rx_load && receive_full && !sw_rst |=> overrun_flag;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed"); // R20
   property p_slave_pcs;
      rx_load && !master && !sw_rst |=> rx_pcs == 4'h0;
   endproperty
   a_slave_pcs: assert property (p_slave_pcs) else $error("slave select nonzero"); // R15
   property p_transmit_empty_off;
      !enabled && !$past(wr_acc) |-> !transmit_empty;
   endproperty
   a_transmit_empty_off: assert property (p_transmit_empty_off) else $error("transmit_empty set while off"); // R19
endmodule
`default_nettype wire

/* File: logic/serial_shifter.sv */
// character serializer, master or slave, mode 0 timing
`timescale 1ns/1ps
`default_nettype none
module serial_shifter
   import serial_periph_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   shift_if.eng sh
);
   logic [7:0] sr;
   logic [3:0] cnt;
   logic [2:0] half;
   logic sck, run, in_bit, sck_d, done;
   logic rise_s, fall_s;
   assign rise_s = sh.sck_in & ~sck_d & ~sh.ss_n;
   assign fall_s = ~sh.sck_in & sck_d & ~sh.ss_n;
   assign sh.busy = run | (cnt != 4'h0);
   assign sh.done = done;
   assign sh.rx_byte = sr;
   assign sh.sck_out = sck;
   assign sh.sdo = sr[7];
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sck_d <= 1'b0;
      end else begin
         sck_d <= sh.sck_in;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sr <= 8'h00;
         cnt <= 4'h0;
         half <= 3'h0;
         sck <= 1'b0;
         run <= 1'b0;
         in_bit <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (sh.start && !sh.busy) begin
            sr <= sh.tx_byte;
            run <= sh.master;
            half <= 3'h0;
            sck <= 1'b0;
         end else if (run) begin
            if (half == SCLK_HALF - 3'h1) begin
               half <= 3'h0;
               sck <= ~sck;
               if (!sck) begin
                  // loopback feeds the serializer its own output
                  in_bit <= sh.loop ? sr[7] : sh.sdi_m; // R12
                  cnt <= cnt + 4'h1;
               end else begin
                  sr <= {sr[6:0], in_bit};
                  if (cnt == CHAR_BITS) begin
                     cnt <= 4'h0;
                     run <= 1'b0;
                     done <= 1'b1;
                  end
               end
            end else begin
               half <= half + 3'h1;
            end
         end else if (!sh.master) begin
            if (rise_s) begin
               in_bit <= sh.sdi_s;
               cnt <= cnt + 4'h1;
            end else if (fall_s && cnt != 4'h0) begin
               sr <= {sr[6:0], in_bit};
               if (cnt == CHAR_BITS) begin
                  cnt <= 4'h0;
                  done <= 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire
